/* File: mab_exec_asserts.sv */
// Checker for the execute core: stall lengths, flag effects, jump target.
// Assumes it is bound to mab_exec_core and sees only its ports.
module mab_exec_asserts
   import mab_pkg::*;
(
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_nrst,
   // Fetch and status
   input wire logic [15:0] i_instr,
   input wire logic        i_instr_valid,
   input wire logic        o_instr_ready,
   input wire logic [9:0]  o_pc,
   input wire logic [7:0]  o_sreg
);
   // Accepted register-format word and its opcode
   wire logic    take = i_instr_valid && o_instr_ready && !i_instr[15];
   wire mab_op_t op   = mab_op_t'(i_instr[14:10]);

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   // Stall shapes: ready low for n cycles, then back
   sequence s_stall1; !o_instr_ready ##1 o_instr_ready; endsequence
   sequence s_stall2; !o_instr_ready [*2] ##1 o_instr_ready; endsequence
   sequence s_stall3; !o_instr_ready [*3] ##1 o_instr_ready; endsequence

   property p_jump;
      take && op == OP_REL_JUMP |=>
         o_pc == $past(o_pc) + $past(i_instr[9:0]) + 10'h001 ##0 s_stall1;
   endproperty
   property p_call;
      take && (op == OP_REL_CALL || op == OP_INDIRECT_CALL) |=> s_stall2;
   endproperty
   property p_ret;
      take && (op == OP_RETURN || op == OP_IRQ_RETURN) |=> s_stall3;
   endproperty
   property p_irq_return_op;
      take && op == OP_IRQ_RETURN |=> o_sreg[7];
   endproperty
   property p_word;
      take && (op == OP_WORD_ADD_IMM || op == OP_WORD_SUB_IMM) |=> s_stall1;
   endproperty
   property p_bitop;
      take && (op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR) |=> s_stall1;
   endproperty
   property p_alu1;
      take && op <= OP_XOR |=> o_instr_ready;
   endproperty
   property p_inc;
      take && (op == OP_INC || op == OP_DEC) |=> o_sreg[0] == $past(o_sreg[0]);
   endproperty
   property p_logic;
      take && op >= OP_AND && op <= OP_XOR |=> !o_sreg[3] && $stable(o_sreg[0]);
   endproperty

   a_jump:  assert property (p_jump) else $error("jump target or stall wrong");
   a_call:  assert property (p_call) else $error("call stall wrong");
   a_ret:   assert property (p_ret) else $error("return stall wrong");
   a_irq_return_op:  assert property (p_irq_return_op) else $error("irq return left I clear");
   a_word:  assert property (p_word) else $error("word op stall wrong");
   a_bitop: assert property (p_bitop) else $error("bit op stall wrong");
   a_alu1:  assert property (p_alu1) else $error("alu op stalled");
   a_inc:   assert property (p_inc) else $error("inc or dec moved carry");
   a_logic: assert property (p_logic) else $error("logic op flags wrong");
endmodule

bind mab_exec_core mab_exec_asserts u_chk (.i_clk, .i_nrst, .i_instr, .i_instr_valid,
   .o_instr_ready, .o_pc, .o_sreg);

/* File: mab_exec_core.sv */
// Execute stage of the 8-bit core: ALU, flags, branches, skips, I/O access.
// Assumes program memory hands one instruction word per cycle with valid,
// and tells whether the word after the current one starts a two-word op.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`include "mab_regs.svh"
module mab_exec_core (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   // Instruction fetch
   input  wire logic [15:0]           i_instr,
   input  wire logic                  i_instr_valid,
   input  wire logic                  i_next_two_word,
   output logic                       o_instr_ready,
   output logic [9:0]                 o_pc,
   // Software register port
   input  wire mab_pkg::mab_bus_req_t i_bus,
   output logic [7:0]                 o_bus_rdata,
   // Status
   output logic [7:0]                 o_sreg
);
   import mab_pkg::*;

   // Carry, half-carry, overflow of an 8-bit add
   function automatic logic [2:0] add_chv(input logic [7:0] a, b, r);
      return {a[7] & b[7] | b[7] & ~r[7] | ~r[7] & a[7],
              a[3] & b[3] | b[3] & ~r[3] | ~r[3] & a[3],
              a[7] & b[7] & ~r[7] | ~a[7] & ~b[7] & r[7]};
   endfunction

   // Borrow, half-borrow, overflow of an 8-bit subtract
   function automatic logic [2:0] sub_chv(input logic [7:0] a, b, r);
      return {~a[7] & b[7] | b[7] & r[7] | r[7] & ~a[7],
              ~a[3] & b[3] | b[3] & r[3] | r[3] & ~a[3],
              a[7] & ~b[7] & ~r[7] | ~a[7] & b[7] & r[7]};
   endfunction

   logic [7:0]  rf_reg [32];
   logic [7:0]  sreg_reg;
   logic [9:0]  pc_reg;
   logic [2:0]  stall_reg;
   logic [7:0]  bus_rdata_reg;
   mab_state_t  state_reg;

   // Decode fields
   logic        imm_fmt;
   mab_op_t     op;
   mab_iop_t    iop;
   logic [4:0]  dst_idx;
   logic [4:0]  src_idx;
   logic [4:0]  pair_lo;
   logic [4:0]  pair_hi;
   logic [7:0]  dst_val;
   logic [7:0]  src_val;
   logic [7:0]  opnd_b;
   logic        accept;

   assign imm_fmt = i_instr[15];
   assign op      = mab_op_t'(i_instr[14:10]);
   assign iop     = mab_iop_t'(i_instr[14:12]);
   assign dst_idx = imm_fmt ? {1'b1, i_instr[11:8]} : i_instr[9:5];
   assign src_idx = i_instr[4:0];
   assign pair_lo = {2'b11, i_instr[9:8], 1'b0};
   assign pair_hi = {2'b11, i_instr[9:8], 1'b1};
   assign dst_val = rf_reg[dst_idx];
   assign src_val = rf_reg[src_idx];
   assign opnd_b  = imm_fmt ? i_instr[7:0] : src_val;
   assign accept  = i_instr_valid && o_instr_ready;

   // Byte arithmetic; carry-in only for the with-carry forms
   logic        use_carry;
   logic        cin;
   logic        neg_op;
   logic [7:0]  sub_a;
   logic [7:0]  sub_b;
   logic [7:0]  add_r;
   logic [7:0]  sub_r;

   assign use_carry = imm_fmt ? (iop == IOP_SUB_CARRY)
                              : (op == OP_ADD_CARRY || op == OP_SUB_CARRY);
   assign cin    = use_carry & sreg_reg[`MAB_FLAG_C];
   assign neg_op = !imm_fmt && op == OP_TWOS_COMP;
   assign sub_a  = neg_op ? `MAB_BYTE_ZERO : dst_val;
   assign sub_b  = neg_op ? dst_val : opnd_b;
   assign add_r  = dst_val + opnd_b + {7'h00, cin};
   assign sub_r  = sub_a - sub_b - {7'h00, cin};

   // Word arithmetic on a high register pair
   logic [15:0] word_v;
   logic [15:0] word_k;
   logic [15:0] word_r;

   assign word_v = {rf_reg[pair_hi], rf_reg[pair_lo]};
   assign word_k = {10'h000, i_instr[5:0]};
   assign word_r = (op == OP_WORD_SUB_IMM) ? word_v - word_k : word_v + word_k;

   // Pointer, I/O addressing and data-space mapping
   logic [15:0] zptr;
   logic [15:0] z_io_off;
   logic        z_is_io;
   logic        z_is_rf;
   logic        bit_form;
   logic [5:0]  io_addr;
   logic [7:0]  io_rdata;
   logic [7:0]  io_val;
   logic        io_bit;

   assign zptr     = {rf_reg[`MAB_ZH_IDX], rf_reg[`MAB_ZL_IDX]};
   assign z_io_off = zptr - `MAB_IO_DATA_BASE;
   assign z_is_io  = zptr >= `MAB_IO_DATA_BASE && zptr <= `MAB_IO_DATA_END;
   assign z_is_rf  = zptr < `MAB_IO_DATA_BASE;
   assign bit_form = op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_SKIP_IO_ONE,
                                OP_SKIP_IO_ZERO};
   // Bit forms carry a 5-bit address, so they reach only the low 32 bytes
   assign io_addr  = bit_form ? {1'b0, i_instr[7:3]} :
                     (op == OP_DATA_LOAD || op == OP_DATA_STORE) ? z_io_off[5:0] :
                     {i_instr[10], i_instr[4:0]};
   assign io_val   = (io_addr == `MAB_SREG_IO) ? sreg_reg : io_rdata;
   assign io_bit   = io_val[i_instr[2:0]];

   // Program counter candidates
   logic [9:0]  pc_inc;
   logic [9:0]  pc_rel;
   logic [9:0]  pc_skip;

   assign pc_inc  = pc_reg + 10'h001;
   assign pc_rel  = pc_reg + i_instr[9:0] + 10'h001;
   assign pc_skip = pc_reg + (i_next_two_word ? 10'h003 : 10'h002);

   // Execute: results, flags, register, I/O and stack effects
   logic [7:0]  res;
   logic [7:0]  fl;
   logic        zn_upd;
   logic        fl_we;
   logic        rf_we;
   logic        hi_we;
   logic [4:0]  rf_widx;
   logic [9:0]  pc_n;
   logic [2:0]  cyc_n;
   logic        skip;
   logic        push;
   logic        pop;
   mab_io_op_t  io_op;
   logic [9:0]  stack_top;

   always_comb
   begin
      res = dst_val;
      fl = sreg_reg;
      zn_upd = 1'b0;
      fl_we = 1'b0;
      rf_we = 1'b0;
      hi_we = 1'b0;
      rf_widx = dst_idx;
      pc_n = pc_inc;
      cyc_n = 3'd1;
      skip = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      io_op = '{addr: io_addr, data: dst_val, wr: 1'b0, bit_op: 1'b0,
                bit_val: 1'b0, bit_idx: i_instr[2:0]};
      if (imm_fmt)
      begin
         rf_we = 1'b1;
         case (iop)
            IOP_SUB, IOP_SUB_CARRY:
            begin
               res = sub_r;
               {fl[`MAB_FLAG_C], fl[`MAB_FLAG_H], fl[`MAB_FLAG_V]} =
                  sub_chv(sub_a, sub_b, sub_r);
               zn_upd = 1'b1;
            end
            IOP_AND:        res = dst_val & opnd_b;
            IOP_SET_BITS:   res = dst_val | opnd_b;
            IOP_CLEAR_BITS: res = dst_val & (`MAB_BYTE_ONES - opnd_b);
            IOP_SET_ALL:    res = `MAB_BYTE_ONES;
            IOP_LOAD:       res = opnd_b;
            default:        rf_we = 1'b0;
         endcase
         // Logic forms clear V and refresh Z, N only
         if (iop inside {IOP_AND, IOP_SET_BITS, IOP_CLEAR_BITS})
         begin
            fl[`MAB_FLAG_V] = 1'b0;
            zn_upd = 1'b1;
         end
      end
      else
      begin
         case (op)
            OP_ADD, OP_ADD_CARRY:
            begin
               res = add_r;
               rf_we = 1'b1;
               {fl[`MAB_FLAG_C], fl[`MAB_FLAG_H], fl[`MAB_FLAG_V]} =
                  add_chv(dst_val, opnd_b, add_r);
               zn_upd = 1'b1;
            end
            OP_SUB, OP_SUB_CARRY, OP_TWOS_COMP:
            begin
               res = sub_r;
               rf_we = 1'b1;
               {fl[`MAB_FLAG_C], fl[`MAB_FLAG_H], fl[`MAB_FLAG_V]} =
                  sub_chv(sub_a, sub_b, sub_r);
               zn_upd = 1'b1;
            end
            // Test and clear are AND and XOR with source equal to destination
            OP_AND, OP_OR, OP_XOR:
            begin
               res = (op == OP_AND) ? dst_val & src_val :
                     (op == OP_OR) ? dst_val | src_val : dst_val ^ src_val;
               rf_we = 1'b1;
               fl[`MAB_FLAG_V] = 1'b0;
               zn_upd = 1'b1;
            end
            OP_ONES_COMP:
            begin
               res = `MAB_BYTE_ONES - dst_val;
               rf_we = 1'b1;
               fl[`MAB_FLAG_C] = 1'b1;
               fl[`MAB_FLAG_V] = 1'b0;
               zn_upd = 1'b1;
            end
            // Carry untouched so multi-byte loops keep their borrow
            OP_INC, OP_DEC:
            begin
               res = (op == OP_INC) ? dst_val + 8'h01 : dst_val - 8'h01;
               rf_we = 1'b1;
               fl[`MAB_FLAG_V] = (op == OP_INC) ? (dst_val == 8'h7f) : (dst_val == 8'h80);
               zn_upd = 1'b1;
            end
            OP_WORD_ADD_IMM, OP_WORD_SUB_IMM:
            begin
               res = word_r[7:0];
               rf_widx = pair_lo;
               rf_we = 1'b1;
               hi_we = 1'b1;
               fl[`MAB_FLAG_Z] = ~|word_r;
               fl[`MAB_FLAG_N] = word_r[15];
               fl[`MAB_FLAG_V] = (op == OP_WORD_ADD_IMM) ? ~word_v[15] & word_r[15]
                                                         : word_v[15] & ~word_r[15];
               fl[`MAB_FLAG_C] = (op == OP_WORD_ADD_IMM) ? ~word_r[15] & word_v[15]
                                                         : word_r[15] & ~word_v[15];
               fl[`MAB_FLAG_S] = fl[`MAB_FLAG_N] ^ fl[`MAB_FLAG_V];
               fl_we = 1'b1;
               cyc_n = `MAB_CYC_WORD;
            end
            OP_REL_JUMP, OP_INDIRECT_JUMP:
            begin
               pc_n = (op == OP_REL_JUMP) ? pc_rel : zptr[9:0];
               cyc_n = `MAB_CYC_JUMP;
            end
            OP_REL_CALL, OP_INDIRECT_CALL:
            begin
               pc_n = (op == OP_REL_CALL) ? pc_rel : zptr[9:0];
               push = 1'b1;
               cyc_n = `MAB_CYC_CALL;
            end
            OP_RETURN, OP_IRQ_RETURN:
            begin
               pc_n = stack_top;
               pop = 1'b1;
               cyc_n = `MAB_CYC_RETURN;
               if (op == OP_IRQ_RETURN)
               begin
                  fl[`MAB_FLAG_I] = 1'b1;
                  fl_we = 1'b1;
               end
            end
            OP_CMP_SKIP_EQ:  skip = dst_val == src_val;
            OP_SKIP_IO_ONE:  skip = io_bit;
            OP_SKIP_IO_ZERO: skip = !io_bit;
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR:
            begin
               io_op.bit_op = 1'b1;
               io_op.bit_val = op == OP_IO_BIT_SET;
               cyc_n = `MAB_CYC_BITOP;
            end
            OP_PORT_IN_LO, OP_PORT_IN_HI:
            begin
               res = io_val;
               rf_we = 1'b1;
            end
            OP_PORT_OUT_LO, OP_PORT_OUT_HI:
            begin
               io_op.wr = 1'b1;
               if (io_addr == `MAB_SREG_IO)
               begin
                  fl = dst_val;
                  fl_we = 1'b1;
               end
            end
            // Data space: registers below the I/O window, nothing above it
            OP_DATA_LOAD:
            begin
               res = z_is_rf ? rf_reg[zptr[4:0]] : z_is_io ? io_val : `MAB_BYTE_ZERO;
               rf_we = 1'b1;
            end
            OP_DATA_STORE:
            begin
               rf_widx = zptr[4:0];
               rf_we = z_is_rf;
               io_op.wr = z_is_io;
               if (z_is_io && io_addr == `MAB_SREG_IO)
               begin
                  fl = dst_val;
                  fl_we = 1'b1;
               end
            end
            default: ;
         endcase
      end
      if (zn_upd)
      begin
         fl[`MAB_FLAG_Z] = ~|res;
         fl[`MAB_FLAG_N] = res[7];
         fl_we = 1'b1;
      end
      // Skipped word count sets the extra cycles
      if (skip)
      begin
         pc_n = pc_skip;
         cyc_n = i_next_two_word ? 3'd3 : 3'd2;
      end
   end

   // Sub-blocks; an idle core still drives the address for its read port
   logic [7:0] bus_peek;
   mab_io_op_t io_core;

   assign io_core = accept ? io_op : mab_io_op_t'{addr: io_addr, default: '0};

   mab_io_space u_io (
      .i_clk        (i_clk),
      .i_nrst       (i_nrst),
      .i_core       (io_core),
      .i_bus        (i_bus),
      .o_core_rdata (io_rdata),
      .o_bus_peek   (bus_peek)
   );

   mab_ret_stack u_stack (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .i_push (accept && push),
      .i_pop  (accept && pop),
      .i_data (pc_inc),
      .o_top  (stack_top)
   );

   // Register file; word forms write both halves at once
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         for (int i = 0; i < 32; i++)
            rf_reg[i] <= `MAB_BYTE_ZERO;
      end
      else if (accept && rf_we)
      begin
         rf_reg[rf_widx] <= res;
         if (hi_we)
            rf_reg[pair_hi] <= word_r[15:8];
      end
   end

   // Sequencer: extra instruction cycles are held as stall cycles
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         pc_reg <= `MAB_PC_RST;
         state_reg <= ST_RUN;
         stall_reg <= 3'd0;
      end
      else
      begin
         case (state_reg)
            ST_RUN:
            begin
               if (accept)
               begin
                  pc_reg <= pc_n;
                  stall_reg <= cyc_n - 3'd1;
                  state_reg <= (cyc_n > 3'd1) ? ST_STALL : ST_RUN;
               end
            end
            ST_STALL:
            begin
               stall_reg <= stall_reg - 3'd1;
               state_reg <= (stall_reg == 3'd1) ? ST_RUN : ST_STALL;
            end
            default: state_reg <= ST_RUN;
         endcase
      end
   end

   // Flags and software read data; the core's flag write beats software
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         sreg_reg <= `MAB_SREG_RST;
         bus_rdata_reg <= `MAB_BYTE_ZERO;
      end
      else
      begin
         if (accept && fl_we)
            sreg_reg <= fl;
         else if (i_bus.wr && i_bus.addr == `MAB_SREG_IO)
            sreg_reg <= i_bus.wdata;
         bus_rdata_reg <= !i_bus.rd ? `MAB_BYTE_ZERO :
                          (i_bus.addr == `MAB_SREG_IO) ? sreg_reg : bus_peek;
      end
   end

   assign o_instr_ready = state_reg == ST_RUN;
   assign o_pc          = pc_reg;
   assign o_sreg        = sreg_reg;
   assign o_bus_rdata   = bus_rdata_reg;

endmodule

/* File: mab_exec_core_bench.sv */
// Self-checking bench for the execute core with a program memory model.
// Assumes programs are loaded into the model just before each reset.
module mab_exec_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import mab_pkg::*;

   localparam logic [15:0] NOP = {1'b0, OP_NOP, 10'h000};
   logic         i_clk  = 1'b0;
   logic         i_nrst = 1'b0;
   logic         slow   = 1'b0;
   mab_bus_req_t i_bus  = '0;
   logic [15:0]  instr;
   logic         valid, two, ready;
   logic [9:0]   pc;
   logic [7:0]   rdata, sreg, d;
   int           num_errors = 0, cmp_count = 0, cycles = 0;

   mab_prog_mem pm (.i_clk, .i_slow(slow), .i_pc(pc), .o_instr(instr), .o_valid(valid),
      .o_next_two(two));
   mab_exec_core dut (.i_clk, .i_nrst, .i_instr(instr), .i_instr_valid(valid),
      .i_next_two_word(two), .o_instr_ready(ready), .o_pc(pc), .i_bus,
      .o_bus_rdata(rdata), .o_sreg(sreg));

   function automatic logic [15:0] rf(mab_op_t o, logic [4:0] a, logic [4:0] b);
      return {1'b0, o, a, b};
   endfunction
   function automatic logic [15:0] im(mab_iop_t o, logic [3:0] a, logic [7:0] k);
      return {1'b1, o, a, k};
   endfunction

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic prog(input logic [15:0] w[$]);
      foreach (pm.mem[a])
      begin
         pm.mem[a] = (a < w.size()) ? w[a] : NOP;
         pm.two_word[a] = 1'b0;
      end
   endtask
   task automatic restart(input logic s);
      @(posedge i_clk);
      i_nrst <= 1'b0;
      slow   <= s;
      repeat (10) @(posedge i_clk);
      i_nrst <= 1'b1;
   endtask
   // Bounded wait; only test_branch compares the pc it ends on
   task automatic wait_pc(input logic [9:0] a);
      for (int n = 0; n < 40 && pc !== a; n++)
      begin
         @(posedge i_clk);
         #1;
      end
   endtask
   task automatic bus(input logic [5:0] a, input logic [7:0] v, input logic w);
      @(posedge i_clk);
      i_bus <= '{a, v, w, !w};
      @(posedge i_clk);
      i_bus <= '0;
      #1;
      d = rdata;
   endtask

   task automatic test_alu();
      prog('{im(IOP_LOAD, 4'd0, 8'h7f), im(IOP_LOAD, 4'd1, 8'h01), rf(OP_ADD, 5'd16, 5'd17),
         rf(OP_PORT_OUT_LO, 5'd16, 5'h01), im(IOP_LOAD, 4'd14, 8'h21),
         rf(OP_DATA_LOAD, 5'd18, 5'd0), rf(OP_PORT_OUT_LO, 5'd18, 5'h02),
         rf(OP_INC, 5'd17, 5'd0), rf(OP_AND, 5'd17, 5'd17), im(IOP_SET_ALL, 4'd4, 8'h00),
         rf(OP_WORD_ADD_IMM, 5'd0, 5'd1), im(IOP_SUB, 4'd4, 8'h01),
         rf(OP_TWOS_COMP, 5'd20, 5'd0), im(IOP_CLEAR_BITS, 4'd4, 8'h02),
         rf(OP_ONES_COMP, 5'd20, 5'd0), rf(OP_PORT_OUT_LO, 5'd20, 5'h03)});
      restart(1'b0);
      wait_pc(10'd3);
      chk(sreg, 8'h2c);
      wait_pc(10'd11);
      chk(sreg, 8'h20);
      wait_pc(10'd16);
      chk(sreg, 8'h25);
      bus(6'h01, 8'h00, 1'b0);
      chk(d, 8'h80);
      bus(6'h02, 8'h00, 1'b0);
      chk(d, 8'h80);
      bus(6'h03, 8'h00, 1'b0);
      chk(d, 8'hff);
      $display("test_alu done");
   endtask

   task automatic test_branch();
      prog('{rf(OP_REL_CALL, 5'd0, 5'd2), rf(OP_REL_JUMP, 5'd0, 5'd3), NOP,
         rf(OP_IRQ_RETURN, 5'd0, 5'd0)});
      restart(1'b1);
      wait_pc(10'd3);
      chk(pc, 10'd3);
      wait_pc(10'd1);
      chk(pc, 10'd1);
      wait_pc(10'd5);
      chk(pc, 10'd5);
      chk(sreg, 8'h80);
      $display("test_branch done");
   endtask

   task automatic test_bits();
      prog('{im(IOP_LOAD, 4'd0, 8'ha5), rf(OP_PORT_OUT_LO, 5'd16, 5'h05),
         {1'b0, OP_IO_BIT_SET, 2'b00, 5'h05, 3'd1}, {1'b0, OP_SKIP_IO_ZERO, 2'b00, 5'h05, 3'd3},
         im(IOP_LOAD, 4'd0, 8'h00), rf(OP_CMP_SKIP_EQ, 5'd16, 5'd16), im(IOP_LOAD, 4'd0, 8'h00),
         im(IOP_LOAD, 4'd0, 8'h00), rf(OP_PORT_OUT_LO, 5'd16, 5'h06),
         {1'b0, OP_IO_BIT_CLEAR, 2'b00, 5'h05, 3'd0},
         {1'b0, OP_SKIP_IO_ONE, 2'b00, 5'h05, 3'd1}, rf(OP_PORT_OUT_LO, 5'd20, 5'h06)});
      pm.two_word[6] = 1'b1;
      restart(1'b0);
      // Ten cycles: 1+1+2+2 (short skip)+3 (long skip)+1
      repeat (10) @(posedge i_clk);
      #1;
      chk(pc, 10'd9);
      wait_pc(10'd13);
      bus(6'h05, 8'h00, 1'b0);
      chk(d, 8'ha6);
      bus(6'h06, 8'h00, 1'b0);
      chk(d, 8'ha5);
      bus(6'h09, 8'h3c, 1'b1);
      bus(6'h09, 8'h00, 1'b0);
      chk(d, 8'h3c);
      $display("test_bits done");
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Clock, and a ceiling well above the fewer than one hundred cycles needed
   initial
   begin
      forever #10 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         num_errors++;
         close_out();
      end
   end

   initial
   begin
      test_alu();
      test_branch();
      test_bits();
      close_out();
   end
endmodule

/* File: mab_io_space.sv */
// I/O register space: 64 bytes, byte writes and single-bit writes.
// Assumes one core access and one software access per cycle.
`include "mab_regs.svh"
module mab_io_space (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_nrst,
   // Core and software access
   input  wire mab_pkg::mab_io_op_t   i_core,
   input  wire mab_pkg::mab_bus_req_t i_bus,
   // Read data
   output logic [7:0]                 o_core_rdata,
   output logic [7:0]                 o_bus_peek
);
   import mab_pkg::*;

   logic [7:0] mem_reg  [`MAB_IO_SIZE];
   logic [7:0] mem_next [`MAB_IO_SIZE];

   // Replace one bit only, so write-one-to-clear neighbours see no write
   function automatic logic [7:0] bit_apply(input logic [7:0] v, input logic [2:0] idx,
                                            input logic bv);
      logic [7:0] r;
      r = v;
      r[idx] = bv;
      return r;
   endfunction

   // Per-byte next value; core beats software on a collision
   generate
      for (genvar g = 0; g < `MAB_IO_SIZE; g++)
      begin : g_byte
         logic core_hit;
         logic bus_hit;
         assign core_hit = i_core.addr == 6'(g);
         assign bus_hit  = i_bus.addr == 6'(g);
         assign mem_next[g] = (core_hit && i_core.wr) ? i_core.data :
                              (core_hit && i_core.bit_op) ?
                              bit_apply(mem_reg[g], i_core.bit_idx, i_core.bit_val) :
                              (bus_hit && i_bus.wr) ? i_bus.wdata : mem_reg[g];
      end
   endgenerate

   // Storage
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         for (int i = 0; i < `MAB_IO_SIZE; i++)
            mem_reg[i] <= `MAB_BYTE_ZERO;
      end
      else
         mem_reg <= mem_next;
   end

   // Read ports
   assign o_core_rdata = mem_reg[i_core.addr];
   assign o_bus_peek   = mem_reg[i_bus.addr];

endmodule

/* File: mab_pkg.sv */
// Types shared by the execute block: opcodes and access bundles.
// Assumes the numeric figures live in mab_regs.svh.
package mab_pkg;

   // Register-format opcodes, instruction bits 14:10
   typedef enum logic [4:0] {
      OP_ADD = 5'h00, OP_ADD_CARRY = 5'h01, OP_SUB = 5'h02, OP_SUB_CARRY = 5'h03,
      OP_AND = 5'h04, OP_OR = 5'h05, OP_XOR = 5'h06, OP_CMP_SKIP_EQ = 5'h07,
      OP_ONES_COMP = 5'h08, OP_TWOS_COMP = 5'h09, OP_INC = 5'h0a, OP_DEC = 5'h0b,
      OP_WORD_ADD_IMM = 5'h0c, OP_WORD_SUB_IMM = 5'h0d, OP_REL_JUMP = 5'h0e,
      OP_REL_CALL = 5'h0f, OP_INDIRECT_JUMP = 5'h10, OP_INDIRECT_CALL = 5'h11,
      OP_RETURN = 5'h12, OP_IRQ_RETURN = 5'h13, OP_IO_BIT_SET = 5'h14,
      OP_IO_BIT_CLEAR = 5'h15, OP_SKIP_IO_ONE = 5'h16, OP_SKIP_IO_ZERO = 5'h17,
      OP_PORT_IN_LO = 5'h18, OP_PORT_IN_HI = 5'h19, OP_PORT_OUT_LO = 5'h1a,
      OP_PORT_OUT_HI = 5'h1b, OP_DATA_LOAD = 5'h1c, OP_DATA_STORE = 5'h1d,
      OP_NOP = 5'h1e, OP_RSVD = 5'h1f
   } mab_op_t;

   // Immediate-format opcodes, instruction bits 14:12
   typedef enum logic [2:0] {
      IOP_SUB = 3'h0, IOP_SUB_CARRY = 3'h1, IOP_AND = 3'h2, IOP_SET_BITS = 3'h3,
      IOP_CLEAR_BITS = 3'h4, IOP_SET_ALL = 3'h5, IOP_LOAD = 3'h6, IOP_NOP = 3'h7
   } mab_iop_t;

   // Software register port request
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } mab_bus_req_t;

   // Core access into I/O space
   typedef struct packed {
      logic [5:0] addr;
      logic [7:0] data;
      logic       wr;
      logic       bit_op;
      logic       bit_val;
      logic [2:0] bit_idx;
   } mab_io_op_t;

   typedef enum logic {ST_RUN, ST_STALL} mab_state_t;

endpackage

/* File: mab_prog_mem.sv */
// Program memory model feeding the execute core one word per cycle.
// Assumes the bench fills mem and two_word just before it asserts reset.
module mab_prog_mem (
   // Clock and pacing
   input  wire logic       i_clk,
   input  wire logic       i_slow,
   // Fetch side
   input  wire logic [9:0] i_pc,
   output logic [15:0]     o_instr,
   output logic            o_valid,
   output logic            o_next_two
);
   logic [15:0] mem [1024];
   logic        two_word [1024];
   logic [1:0]  cnt_reg = 2'h0;

   // Slow mode drops valid one cycle in four
   always @(posedge i_clk)
   begin
      cnt_reg <= cnt_reg + 2'h1;
   end

   // An invalid word is scrambled so it cannot pass for the real one
   assign o_valid    = !(i_slow && cnt_reg == 2'h0);
   assign o_instr    = o_valid ? mem[i_pc] : ~mem[i_pc];
   assign o_next_two = two_word[i_pc + 10'h001];
endmodule

/* File: mab_regs.svh */
// Offsets, field positions, reset values and cycle counts of the execute block.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef MAB_REGS_SVH
`define MAB_REGS_SVH

// I/O space layout
`define MAB_IO_SIZE        64
`define MAB_IO_BITOP_LAST  6'h1f
`define MAB_IO_LAST        6'h3f
`define MAB_IO_DATA_BASE   16'h0020
`define MAB_IO_DATA_END    16'h005f
`define MAB_SREG_IO        6'h3f

// Reset values and constants
`define MAB_SREG_RST       8'h00
`define MAB_PC_RST         10'h000
`define MAB_BYTE_ONES      8'hff
`define MAB_BYTE_ZERO      8'h00

// Status flag positions
`define MAB_FLAG_C         0
`define MAB_FLAG_Z         1
`define MAB_FLAG_N         2
`define MAB_FLAG_V         3
`define MAB_FLAG_S         4
`define MAB_FLAG_H         5
`define MAB_FLAG_I         7

// Instruction cycle counts
`define MAB_CYC_WORD       3'd2
`define MAB_CYC_JUMP       3'd2
`define MAB_CYC_CALL       3'd3
`define MAB_CYC_RETURN     3'd4
`define MAB_CYC_BITOP      3'd2

// Register file and stack
`define MAB_ZL_IDX         5'd30
`define MAB_ZH_IDX         5'd31
`define MAB_STACK_DEPTH    16

`endif

/* File: mab_ret_stack.sv */
// Return-address stack for calls and returns.
// Assumes push and pop never in the same cycle; overflow wraps silently.
`include "mab_regs.svh"
module mab_ret_stack (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   // Push and pop
   input  wire logic       i_push,
   input  wire logic       i_pop,
   input  wire logic [9:0] i_data,
   output logic [9:0]      o_top
);
   import mab_pkg::*;

   logic [9:0] mem_reg [`MAB_STACK_DEPTH];
   logic [3:0] sp_reg;
   logic [3:0] sp_dec;

   assign sp_dec = sp_reg - 4'h1;
   assign o_top  = mem_reg[sp_dec];

   // Pointer and entry update
   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
         sp_reg <= 4'h0;
      else if (i_push)
      begin
         mem_reg[sp_reg] <= i_data;
         sp_reg <= sp_reg + 4'h1;
      end
      else if (i_pop)
         sp_reg <= sp_dec;
   end

endmodule
